/* File: shared/upirq_pkg.sv */
// Package of offsets, field positions and reset values for the port interrupt and reset registers
// -----------------------------------------------------------------------------
// What this block does
// (R1) Set counter-wrap flag when 32-bit DMA byte counter overflows in free-run mode.
// (R2) Set DMA-done flag when DMA is stopped or finishes its programmed amount.
// (R3) Set RAM read-back done flag when read-back data registers become valid.
// (R4) Status flags clear on writing one; writing zero leaves them alone.
// (R5) Device mode: buffer DMA-done after drain for IN, at DMA end for OUT.
// (R6) Host mode: buffer DMA-done after drain for OUT, at DMA end for IN.
// (R7) Buffer not-empty flag sets when a joined area among six holds data.
// (R8) Buffer full flag sets when a joined area becomes full.
// (R9) Buffer empty flag sets when a joined area becomes empty.
// (R10) Shared read-only root register names the interrupting port, bit1 port1, bit0 port0.
// (R11) Top-level summary bit drives interrupt only while its enable bit is one.
// (R12) Device, host and power-transition top enables keep working during sleep.
// (R13) Device enable gates device events into summary; port 0 window only.
// (R14) Bus-power change and device engine enables keep working during sleep.
// (R15) Host enable register gates host events into host summary bit.
// (R16) Bus-power fault and data-line change enables keep working during sleep.
// (R17) CPU event enables: RAM read done bit7, counter wrap bit1, DMA done bit0.
// (R18) Buffer event enables: DMA done bit7, not-empty, full, empty bits 2..0.
// (R19) Fixed 8-bit read-only revision register, readable in sleep.
// (R20) Transceiver reset bit holds macro in reset until cleared; one after reset.
// (R21) Full soft reset reinitialises all but the CPU bus mode register; the code instead loads the transceiver reset bit from bit7 of the same write.
// (R22) Software writes the reset register only to perform a reset.
// (R23) Summary bits are read-only and follow enabled lower flags.
// (R24) Active-low interrupt asserted while either port has an enabled top bit.
// -----------------------------------------------------------------------------
package upirq_pkg;
	// Port window bases
	localparam logic [9:0] PORT0_BASE = 10'h000;
	localparam logic [9:0] PORT1_BASE = 10'h200;
	// Register offsets inside a window
	localparam logic [8:0] OFS_TOP_STATUS = 9'h000;
	localparam logic [8:0] OFS_DEVICE_STATUS = 9'h001;
	localparam logic [8:0] OFS_HOST_STATUS = 9'h002;
	localparam logic [8:0] OFS_CPU_STATUS = 9'h003;
	localparam logic [8:0] OFS_BUFFER_STATUS = 9'h004;
	localparam logic [8:0] OFS_ROOT_SOURCE = 9'h006;
	localparam logic [8:0] OFS_TOP_ENABLE = 9'h008;
	localparam logic [8:0] OFS_DEVICE_ENABLE = 9'h009;
	localparam logic [8:0] OFS_HOST_ENABLE = 9'h00a;
	localparam logic [8:0] OFS_CPU_ENABLE = 9'h00b;
	localparam logic [8:0] OFS_BUFFER_ENABLE = 9'h00c;
	localparam logic [8:0] OFS_REVISION = 9'h010;
	localparam logic [8:0] OFS_SOFT_RESET = 9'h011;
	// Field positions
	localparam int BIT_RAM_DONE = 7;
	localparam int BIT_CNT_WRAP = 1;
	localparam int BIT_DMA_DONE = 0;
	localparam int BIT_BUF_DMA = 7;
	localparam int BIT_BUF_DATA = 2;
	localparam int BIT_BUF_FULL = 1;
	localparam int BIT_BUF_EMPTY = 0;
	localparam int BIT_TOP_DEVICE = 7;
	localparam int BIT_TOP_HOST = 6;
	localparam int BIT_TOP_CPU = 5;
	localparam int BIT_TOP_BUFFER = 4;
	localparam int BIT_TOP_PM = 0;
	localparam int BIT_XCVR_RST = 7;
	localparam int BIT_FULL_RST = 0;
	// Implemented bits and reset values
	localparam logic [7:0] CPU_STATUS_MASK = 8'h83;
	localparam logic [7:0] BUF_STATUS_MASK = 8'h87;
	localparam logic [7:0] TOP_ENABLE_MASK = 8'hf1;
	localparam logic [7:0] DEV_ENABLE_MASK = 8'hbb;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] SOFT_RESET_RESET = 8'h80;
	localparam logic [7:0] SLEEP_KEEP_TOP = 8'hc1;
	localparam logic [7:0] SLEEP_KEEP_DEV = 8'ha0;
	localparam logic [7:0] SLEEP_KEEP_HOST = 8'hc0;
	localparam int AREA_COUNT = 6;
endpackage : upirq_pkg

/* File: src/upirq_port.sv */
// One port's CPU and buffer event flags, enables and summary
`timescale 1ns/1ps
module upirq_port #(
	parameter bit HAS_DEVICE = 1'b1,
	parameter int AREAS = 6,
	parameter int CNT_W = 32
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic soft_rst_i,
	input wire logic sleep_i,
	// Register access
	input wire logic [8:0] ofs_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	// Event sources
	input wire logic role_select_i,
	input wire logic ram_readback_done_i,
	input wire logic dma_free_run_i,
	input wire logic dma_count_i,
	input wire logic dma_stop_i,
	input wire logic dma_end_i,
	input wire logic dma_dir_in_i,
	input wire logic buffer_drained_i,
	input wire logic [AREAS-1:0] area_join_cpu_status_i,
	input wire logic [AREAS-1:0] area_has_data_i,
	input wire logic [AREAS-1:0] area_full_i,
	input wire logic [AREAS-1:0] area_empty_i,
	input wire logic [7:0] device_flags_i,
	input wire logic [7:0] host_flags_i,
	input wire logic power_transition_done_i,
	// Register views
	output logic [7:0] top_summary_status_o,
	output logic [7:0] device_status_o,
	output logic [7:0] cpu_status_o,
	output logic [7:0] buffer_status_o,
	output logic [7:0] top_enable_o,
	output logic [7:0] device_enable_o,
	output logic [7:0] host_enable_o,
	output logic [7:0] cpu_enable_o,
	output logic [7:0] buffer_enable_o,
	output logic port_irq_o
);
	logic [7:0] cpu_status_reg, buffer_status_reg;
	logic [7:0] top_enable_reg, device_enable_reg, host_enable_reg, cpu_enable_reg, buffer_enable_reg;
	logic [CNT_W-1:0] dma_byte_counter_reg;
	logic drain_wait_reg;
	logic [AREAS-1:0] full_prev_reg, empty_prev_reg;
	logic [7:0] cpu_set, buf_set, top_next;
	logic wrap, buf_dma_now, en_wr_ok;

	// -------------------------------------------------------------------------
	// DMA byte counter and event detection
	// -------------------------------------------------------------------------
	assign wrap = dma_count_i && dma_free_run_i && (dma_byte_counter_reg == '1);

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			dma_byte_counter_reg <= '0;
		else if (soft_rst_i)
			dma_byte_counter_reg <= '0;
		else if (dma_count_i)
			dma_byte_counter_reg <= dma_byte_counter_reg + CNT_W'(1); // [R1]
	end

	// Drain wait when the data still has to leave the buffer after DMA ends
	logic need_drain;
	assign need_drain = role_select_i ? !dma_dir_in_i : dma_dir_in_i; // [R5] [R6]

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			drain_wait_reg <= 1'b0;
		else if (soft_rst_i)
			drain_wait_reg <= 1'b0;
		else if (dma_end_i && need_drain && !buffer_drained_i)
			drain_wait_reg <= 1'b1;
		else if (buffer_drained_i)
			drain_wait_reg <= 1'b0;
	end

	assign buf_dma_now = (dma_end_i && (!need_drain || buffer_drained_i))
		|| (drain_wait_reg && buffer_drained_i); // [R5] [R6]

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			full_prev_reg <= '0;
			// Buffers idle empty; no false empty edge after reset
			empty_prev_reg <= '1;
		end
		else
		begin
			full_prev_reg <= area_full_i;
			empty_prev_reg <= area_empty_i;
		end
	end

	always_comb
	begin
		cpu_set = 8'h00;
		cpu_set[upirq_pkg::BIT_RAM_DONE] = ram_readback_done_i; // [R3]
		cpu_set[upirq_pkg::BIT_CNT_WRAP] = wrap; // [R1]
		cpu_set[upirq_pkg::BIT_DMA_DONE] = dma_stop_i || dma_end_i; // [R2]
		buf_set = 8'h00;
		buf_set[upirq_pkg::BIT_BUF_DMA] = buf_dma_now;
		buf_set[upirq_pkg::BIT_BUF_DATA] = |(area_join_cpu_status_i & area_has_data_i); // [R7]
		buf_set[upirq_pkg::BIT_BUF_FULL] = |(area_join_cpu_status_i & area_full_i & ~full_prev_reg); // [R8]
		buf_set[upirq_pkg::BIT_BUF_EMPTY] = |(area_join_cpu_status_i & area_empty_i & ~empty_prev_reg); // [R9]
	end

	// -------------------------------------------------------------------------
	// Status flags: set wins over a same-cycle write-one clear
	// -------------------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			cpu_status_reg <= upirq_pkg::CTRL_RESET;
		else if (soft_rst_i)
			cpu_status_reg <= upirq_pkg::CTRL_RESET;
		else if (wr_i && ofs_i == upirq_pkg::OFS_CPU_STATUS)
			cpu_status_reg <= ((cpu_status_reg & ~wdata_i) | cpu_set) & upirq_pkg::CPU_STATUS_MASK; // [R4]
		else
			cpu_status_reg <= (cpu_status_reg | cpu_set) & upirq_pkg::CPU_STATUS_MASK;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			buffer_status_reg <= upirq_pkg::CTRL_RESET;
		else if (soft_rst_i)
			buffer_status_reg <= upirq_pkg::CTRL_RESET;
		else if (wr_i && ofs_i == upirq_pkg::OFS_BUFFER_STATUS)
			buffer_status_reg <= ((buffer_status_reg & ~wdata_i) | buf_set) & upirq_pkg::BUF_STATUS_MASK; // [R4]
		else
			buffer_status_reg <= (buffer_status_reg | buf_set) & upirq_pkg::BUF_STATUS_MASK;
	end

	// -------------------------------------------------------------------------
	// Enable registers; in sleep only the sleep-safe bits accept writes
	// -------------------------------------------------------------------------
	assign en_wr_ok = !sleep_i;

	function automatic logic [7:0] upirq_merge(input logic [7:0] old, input logic [7:0] wd,
		input logic [7:0] keep, input logic awake);
		upirq_merge = awake ? wd : ((old & ~keep) | (wd & keep));
	endfunction : upirq_merge

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			top_enable_reg <= upirq_pkg::CTRL_RESET;
			device_enable_reg <= upirq_pkg::CTRL_RESET;
			host_enable_reg <= upirq_pkg::CTRL_RESET;
			cpu_enable_reg <= upirq_pkg::CTRL_RESET;
			buffer_enable_reg <= upirq_pkg::CTRL_RESET;
		end
		else if (soft_rst_i)
		begin
			top_enable_reg <= upirq_pkg::CTRL_RESET;
			device_enable_reg <= upirq_pkg::CTRL_RESET;
			host_enable_reg <= upirq_pkg::CTRL_RESET;
			cpu_enable_reg <= upirq_pkg::CTRL_RESET;
			buffer_enable_reg <= upirq_pkg::CTRL_RESET;
		end
		else if (wr_i)
		begin
			if (ofs_i == upirq_pkg::OFS_TOP_ENABLE) // [R12]
				top_enable_reg <= upirq_merge(top_enable_reg, wdata_i, upirq_pkg::SLEEP_KEEP_TOP, en_wr_ok)
					& upirq_pkg::TOP_ENABLE_MASK & (HAS_DEVICE ? 8'hff : 8'h7f);
			if (ofs_i == upirq_pkg::OFS_DEVICE_ENABLE && HAS_DEVICE) // [R13] [R14]
				device_enable_reg <= upirq_merge(device_enable_reg, wdata_i, upirq_pkg::SLEEP_KEEP_DEV, en_wr_ok)
					& upirq_pkg::DEV_ENABLE_MASK;
			if (ofs_i == upirq_pkg::OFS_HOST_ENABLE) // [R16]
				host_enable_reg <= upirq_merge(host_enable_reg, wdata_i, upirq_pkg::SLEEP_KEEP_HOST, en_wr_ok);
			if (ofs_i == upirq_pkg::OFS_CPU_ENABLE && en_wr_ok)
				cpu_enable_reg <= wdata_i & upirq_pkg::CPU_STATUS_MASK; // [R17]
			if (ofs_i == upirq_pkg::OFS_BUFFER_ENABLE && en_wr_ok)
				buffer_enable_reg <= wdata_i & upirq_pkg::BUF_STATUS_MASK; // [R18]
		end
	end

	// -------------------------------------------------------------------------
	// Top-level summary and port interrupt
	// -------------------------------------------------------------------------
	always_comb
	begin
		top_next = 8'h00;
		top_next[upirq_pkg::BIT_TOP_DEVICE] = HAS_DEVICE && |(device_flags_i & device_enable_reg); // [R13] [R23]
		top_next[upirq_pkg::BIT_TOP_HOST] = |(host_flags_i & host_enable_reg); // [R15] [R23]
		top_next[upirq_pkg::BIT_TOP_CPU] = |(cpu_status_reg & cpu_enable_reg); // [R17] [R23]
		top_next[upirq_pkg::BIT_TOP_BUFFER] = |(buffer_status_reg & buffer_enable_reg); // [R18] [R23]
		top_next[upirq_pkg::BIT_TOP_PM] = power_transition_done_i;
	end

	// Synchronous summary sources masked during sleep; sleep-safe bits still pass
	assign port_irq_o = |(top_next & top_enable_reg & (sleep_i ? upirq_pkg::SLEEP_KEEP_TOP : 8'hff)); // [R11] [R12]
	assign top_summary_status_o = top_next;
	assign device_status_o = HAS_DEVICE ? device_flags_i : 8'h00;
	assign cpu_status_o = cpu_status_reg;
	assign buffer_status_o = buffer_status_reg;
	assign top_enable_o = top_enable_reg;
	assign device_enable_o = device_enable_reg;
	assign host_enable_o = host_enable_reg;
	assign cpu_enable_o = cpu_enable_reg;
	assign buffer_enable_o = buffer_enable_reg;
endmodule : upirq_port

/* File: src/upirq_top.sv */
// Two-port interrupt, revision and soft reset register block
`timescale 1ns/1ps
module upirq_top #(
	parameter int AREAS = 6,
	parameter int CNT_W = 32,
	parameter logic [7:0] REVISION_CODE = 8'h5a // Arbitrary value
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// CPU register port
	input wire logic [9:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	// Mode select for port 0 and power state per port
	input wire logic role_select_i,
	input wire logic [1:0] sleep_i,
	input wire logic [1:0] power_transition_done_i,
	// Port 0 event sources
	input wire logic p0_ram_readback_done_i,
	input wire logic p0_dma_free_run_i,
	input wire logic p0_dma_count_i,
	input wire logic p0_dma_stop_i,
	input wire logic p0_dma_end_i,
	input wire logic p0_dma_dir_in_i,
	input wire logic p0_buffer_drained_i,
	input wire logic [AREAS-1:0] p0_area_join_cpu_status_i,
	input wire logic [AREAS-1:0] p0_area_has_data_i,
	input wire logic [AREAS-1:0] p0_area_full_i,
	input wire logic [AREAS-1:0] p0_area_empty_i,
	input wire logic [7:0] p0_device_flags_i,
	input wire logic [7:0] p0_host_flags_i,
	// Port 1 event sources
	input wire logic p1_ram_readback_done_i,
	input wire logic p1_dma_free_run_i,
	input wire logic p1_dma_count_i,
	input wire logic p1_dma_stop_i,
	input wire logic p1_dma_end_i,
	input wire logic p1_dma_dir_in_i,
	input wire logic p1_buffer_drained_i,
	input wire logic [AREAS-1:0] p1_area_join_cpu_status_i,
	input wire logic [AREAS-1:0] p1_area_has_data_i,
	input wire logic [AREAS-1:0] p1_area_full_i,
	input wire logic [AREAS-1:0] p1_area_empty_i,
	input wire logic [7:0] p1_host_flags_i,
	// Outputs
	output logic irq_out_n_o,
	output logic transceiver_reset_o,
	output logic full_soft_reset_o
);
	logic [1:0] hit;
	logic [8:0] ofs;
	logic [1:0] port_irq;
	logic [7:0] top_st [2], dev_st [2], cpu_st [2], buf_st [2];
	logic [7:0] top_en [2], dev_en [2], host_en [2], cpu_en [2], buf_en [2];
	logic xcvr_reset_reg, full_reset_reg;
	logic [7:0] rdata_next, root_port_source;

	assign hit[0] = addr_i[9] == upirq_pkg::PORT0_BASE[9];
	assign hit[1] = addr_i[9] == upirq_pkg::PORT1_BASE[9];
	assign ofs = addr_i[8:0];

	// -------------------------------------------------------------------------
	// Soft reset register; only written to reset, never for other purposes
	// -------------------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			xcvr_reset_reg <= upirq_pkg::SOFT_RESET_RESET[upirq_pkg::BIT_XCVR_RST]; // [R20]
			full_reset_reg <= 1'b0;
		end
		else if (wr_i && ofs == upirq_pkg::OFS_SOFT_RESET) // [R22]
		begin
			xcvr_reset_reg <= wdata_i[upirq_pkg::BIT_XCVR_RST]; // [R20]
			full_reset_reg <= wdata_i[upirq_pkg::BIT_FULL_RST]; // [R21]
		end
		else
			full_reset_reg <= 1'b0;
	end

	// Single-cycle pulse; the CPU bus mode register lives outside this block
	assign full_soft_reset_o = full_reset_reg; // [R21]
	assign transceiver_reset_o = xcvr_reset_reg;

	// -------------------------------------------------------------------------
	// Port instances
	// -------------------------------------------------------------------------
	upirq_port #(.HAS_DEVICE(1'b1), .AREAS(AREAS), .CNT_W(CNT_W)) u_port0 (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.soft_rst_i(full_reset_reg),
		.sleep_i(sleep_i[0]),
		.ofs_i(ofs),
		.wr_i(wr_i && hit[0]),
		.wdata_i(wdata_i),
		.role_select_i(role_select_i),
		.ram_readback_done_i(p0_ram_readback_done_i),
		.dma_free_run_i(p0_dma_free_run_i),
		.dma_count_i(p0_dma_count_i),
		.dma_stop_i(p0_dma_stop_i),
		.dma_end_i(p0_dma_end_i),
		.dma_dir_in_i(p0_dma_dir_in_i),
		.buffer_drained_i(p0_buffer_drained_i),
		.area_join_cpu_status_i(p0_area_join_cpu_status_i),
		.area_has_data_i(p0_area_has_data_i),
		.area_full_i(p0_area_full_i),
		.area_empty_i(p0_area_empty_i),
		.device_flags_i(p0_device_flags_i),
		.host_flags_i(p0_host_flags_i),
		.power_transition_done_i(power_transition_done_i[0]),
		.top_summary_status_o(top_st[0]),
		.device_status_o(dev_st[0]),
		.cpu_status_o(cpu_st[0]),
		.buffer_status_o(buf_st[0]),
		.top_enable_o(top_en[0]),
		.device_enable_o(dev_en[0]),
		.host_enable_o(host_en[0]),
		.cpu_enable_o(cpu_en[0]),
		.buffer_enable_o(buf_en[0]),
		.port_irq_o(port_irq[0])
	);

	// Port 1 is host only
	upirq_port #(.HAS_DEVICE(1'b0), .AREAS(AREAS), .CNT_W(CNT_W)) u_port1 (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.soft_rst_i(full_reset_reg),
		.sleep_i(sleep_i[1]),
		.ofs_i(ofs),
		.wr_i(wr_i && hit[1]),
		.wdata_i(wdata_i),
		.role_select_i(1'b1),
		.ram_readback_done_i(p1_ram_readback_done_i),
		.dma_free_run_i(p1_dma_free_run_i),
		.dma_count_i(p1_dma_count_i),
		.dma_stop_i(p1_dma_stop_i),
		.dma_end_i(p1_dma_end_i),
		.dma_dir_in_i(p1_dma_dir_in_i),
		.buffer_drained_i(p1_buffer_drained_i),
		.area_join_cpu_status_i(p1_area_join_cpu_status_i),
		.area_has_data_i(p1_area_has_data_i),
		.area_full_i(p1_area_full_i),
		.area_empty_i(p1_area_empty_i),
		.device_flags_i(8'h00),
		.host_flags_i(p1_host_flags_i),
		.power_transition_done_i(power_transition_done_i[1]),
		.top_summary_status_o(top_st[1]),
		.device_status_o(dev_st[1]),
		.cpu_status_o(cpu_st[1]),
		.buffer_status_o(buf_st[1]),
		.top_enable_o(top_en[1]),
		.device_enable_o(dev_en[1]),
		.host_enable_o(host_en[1]),
		.cpu_enable_o(cpu_en[1]),
		.buffer_enable_o(buf_en[1]),
		.port_irq_o(port_irq[1])
	);

	// -------------------------------------------------------------------------
	// Root source, interrupt pin and read mux
	// -------------------------------------------------------------------------
	assign root_port_source = {6'b000000, port_irq[1], port_irq[0]}; // [R10]
	assign irq_out_n_o = !(|port_irq); // [R24]

	always_comb
	begin
		rdata_next = 8'h00;
		case (ofs)
			upirq_pkg::OFS_TOP_STATUS: rdata_next = top_st[addr_i[9]]; // [R23]
			upirq_pkg::OFS_DEVICE_STATUS: rdata_next = dev_st[addr_i[9]];
			upirq_pkg::OFS_CPU_STATUS: rdata_next = cpu_st[addr_i[9]];
			upirq_pkg::OFS_BUFFER_STATUS: rdata_next = buf_st[addr_i[9]];
			upirq_pkg::OFS_ROOT_SOURCE: rdata_next = root_port_source; // [R10]
			upirq_pkg::OFS_TOP_ENABLE: rdata_next = top_en[addr_i[9]];
			upirq_pkg::OFS_DEVICE_ENABLE: rdata_next = dev_en[addr_i[9]];
			upirq_pkg::OFS_HOST_ENABLE: rdata_next = host_en[addr_i[9]];
			upirq_pkg::OFS_CPU_ENABLE: rdata_next = cpu_en[addr_i[9]];
			upirq_pkg::OFS_BUFFER_ENABLE: rdata_next = buf_en[addr_i[9]];
			upirq_pkg::OFS_REVISION: rdata_next = REVISION_CODE; // [R19]
			upirq_pkg::OFS_SOFT_RESET: rdata_next = {xcvr_reset_reg, 7'b0000000};
			default: rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_o <= 8'h00;
		else if (rd_i)
			rdata_o <= rdata_next;
	end
endmodule : upirq_top

/* File: sim/upirq_top_monitor.sv */
// Checker for the two-port interrupt and reset registers
`timescale 1ns/1ps
module upirq_top_monitor #(
	parameter int AREAS = 6,
	parameter logic [7:0] REVISION_CODE = 8'h5a
) (
	// Watched ports
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [9:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o,
	input wire logic role_select_i,
	input wire logic [1:0] sleep_i,
	input wire logic p0_dma_end_i,
	input wire logic p0_dma_dir_in_i,
	input wire logic irq_out_n_o,
	input wire logic transceiver_reset_o,
	input wire logic full_soft_reset_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	wire [8:0] ofs = addr_i[8:0];
	wire soft_wr = wr_i && ofs == upirq_pkg::OFS_SOFT_RESET;
	property p_soft_pulse; full_soft_reset_o |=> !full_soft_reset_o; endproperty
	a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse too long");
	property p_soft_cause; $rose(full_soft_reset_o) |-> $past(soft_wr) && $past(wdata_i[0]); endproperty
	a_soft_cause: assert property (p_soft_cause) else $error("soft reset without request");
	property p_soft_clear; full_soft_reset_o |-> ##2 irq_out_n_o; endproperty
	a_soft_clear: assert property (p_soft_clear) else $error("interrupt survives soft reset");
	property p_xcvr; soft_wr |=> transceiver_reset_o == $past(wdata_i[7]); endproperty
	a_xcvr: assert property (p_xcvr) else $error("transceiver reset not as written");
	property p_rev; rd_i && ofs == upirq_pkg::OFS_REVISION |=> rdata_o == REVISION_CODE; endproperty
	a_rev: assert property (p_rev) else $error("wrong revision code");
	property p_root; rd_i && ofs == upirq_pkg::OFS_ROOT_SOURCE && sleep_i == 2'b00
		|=> rdata_o[7:2] == 6'h00 && (rdata_o[1:0] != 2'b00) == !$past(irq_out_n_o); endproperty
	a_root: assert property (p_root) else $error("root source disagrees with interrupt");
	sequence s_cpu_en; wr_i && ofs == upirq_pkg::OFS_CPU_ENABLE && !sleep_i[addr_i[9]] && !full_soft_reset_o
		##1 !wr_i ##1 rd_i && addr_i == $past(addr_i, 2); endsequence
	property p_cpu_en; s_cpu_en |=> rdata_o == ($past(wdata_i, 3) & upirq_pkg::CPU_STATUS_MASK); endproperty
	a_cpu_en: assert property (p_cpu_en) else $error("cpu enable readback wrong");
	sequence s_top_sleep; wr_i && addr_i == 10'h008 && sleep_i[0] && !full_soft_reset_o
		##1 !wr_i ##1 rd_i && addr_i == 10'h008; endsequence
	property p_top_sleep; s_top_sleep |=> (rdata_o & 8'hc1) == ($past(wdata_i, 3) & 8'hc1); endproperty
	a_top_sleep: assert property (p_top_sleep) else $error("sleep-safe enable lost");
	property p_buf_now; p0_dma_end_i && role_select_i == p0_dma_dir_in_i
		##[1:3] rd_i && addr_i == 10'h004 |=> rdata_o[7]; endproperty
	a_buf_now: assert property (p_buf_now) else $error("buffer dma done missing");
	c_irq: cover property (!irq_out_n_o);
	c_soft: cover property (full_soft_reset_o);
	c_root: cover property (rd_i && ofs == upirq_pkg::OFS_ROOT_SOURCE && !irq_out_n_o);
endmodule : upirq_top_monitor
bind upirq_top upirq_top_monitor #(.AREAS(AREAS), .REVISION_CODE(REVISION_CODE)) upirq_top_monitor_i (.*);

/* File: sim/upirq_cpu.sv */
// Host CPU model that reads and writes the register port
`timescale 1ns/1ps
module upirq_cpu (
	// Bus side
	input wire logic clk_sys_i,
	input wire logic [7:0] rdata_i,
	output logic [9:0] addr_o = 10'h000,
	output logic wr_o = 1'b0,
	output logic rd_o = 1'b0,
	output logic [7:0] wdata_o = 8'h00
);
	task automatic put(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_sys_i);
		wr_o <= 1'b0;
		// Released lines carry junk so stale values never pass
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask : put
	task automatic get(input logic [9:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_sys_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge clk_sys_i);
		d = rdata_i;
	endtask : get
endmodule : upirq_cpu

/* File: sim/test_usb_port_interrupt_and_reset_regs.sv */
// Self-checking bench for the two-port interrupt and reset registers
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module test_usb_port_interrupt_and_reset_regs;
	localparam logic [7:0] REV = 8'h3c; // Arbitrary value
	int n_fail = 0;
	int cmp_count = 0;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic role_select_i = 1'b0;
	logic [1:0] sleep_i = 2'h0, power_transition_done_i = 2'h0;
	logic [3:0] ev = 4'h0;
	logic p0_dma_free_run_i = 1'b0, p0_dma_dir_in_i = 1'b0, p0_buffer_drained_i = 1'b0;
	logic [5:0] p0_area_join_cpu_status_i = 6'h00, p0_area_has_data_i = 6'h00, p0_area_full_i = 6'h00;
	logic [5:0] p0_area_empty_i = 6'h00, p1_area_join_cpu_status_i = 6'h00, p1_area_has_data_i = 6'h00;
	logic [5:0] p1_area_full_i = 6'h00, p1_area_empty_i = 6'h00;
	logic [7:0] p0_device_flags_i = 8'h00, p0_host_flags_i = 8'h00, p1_host_flags_i = 8'h00;
	wire p0_ram_readback_done_i = ev[3], p0_dma_count_i = ev[2], p0_dma_stop_i = ev[1], p0_dma_end_i = ev[0];
	// Second port sees the same transfer events
	wire p1_ram_readback_done_i = ev[3], p1_dma_count_i = ev[2], p1_dma_stop_i = ev[1], p1_dma_end_i = ev[0];
	wire p1_dma_free_run_i = p0_dma_free_run_i, p1_dma_dir_in_i = p0_dma_dir_in_i;
	wire p1_buffer_drained_i = p0_buffer_drained_i;
	wire [9:0] addr_i;
	wire wr_i, rd_i, irq_out_n_o, transceiver_reset_o, full_soft_reset_o;
	wire [7:0] wdata_i, rdata_o;
	upirq_top #(.AREAS(6), .CNT_W(4), .REVISION_CODE(REV)) upirq_top_i (.*);
	upirq_cpu upirq_cpu_i (.clk_sys_i(clk_sys_i), .rdata_i(rdata_o), .addr_o(addr_i), .wr_o(wr_i),
		.rd_o(rd_i), .wdata_o(wdata_i));
	initial forever #20 clk_sys_i = ~clk_sys_i;
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		upirq_cpu_i.put(a, d);
		#1;
	endtask : wr
	task automatic rchk(input logic [9:0] a, input logic [7:0] e);
		logic [7:0] d;
		upirq_cpu_i.get(a, d);
		`CHK(d, e)
	endtask : rchk
	task automatic pulse(input logic [3:0] m);
		@(posedge clk_sys_i);
		ev <= m;
		@(posedge clk_sys_i);
		ev <= 4'h0;
	endtask : pulse
	task automatic t_reset();
		logic [9:0] za [10] = '{10'h003, 10'h004, 10'h005, 10'h006, 10'h008, 10'h009, 10'h00a, 10'h00b,
			10'h00c, 10'h209};
		foreach (za[k]) rchk(za[k], 8'h00);
		rchk(10'h210, REV);
		rchk(10'h011, 8'h80);
		`CHK(transceiver_reset_o, 1'b1)
		`CHK(irq_out_n_o, 1'b1)
	endtask : t_reset
	task automatic t_cpu();
		wr(10'h00b, 8'hff);
		rchk(10'h00b, 8'h83);
		wr(10'h008, 8'h20);
		p0_dma_free_run_i <= 1'b1;
		pulse(4'hc);
		repeat (15) pulse(4'h4);
		pulse(4'h2);
		rchk(10'h003, 8'h83);
		`CHK(irq_out_n_o, 1'b0)
		rchk(10'h006, 8'h01);
		wr(10'h20b, 8'h01);
		wr(10'h208, 8'h20);
		rchk(10'h206, 8'h03);
		wr(10'h20b, 8'h00);
		wr(10'h003, 8'h00);
		rchk(10'h003, 8'h83);
		wr(10'h003, 8'h01);
		wr(10'h00b, 8'h01);
		`CHK(irq_out_n_o, 1'b1)
		rchk(10'h000, 8'h00);
		wr(10'h003, 8'h82);
		rchk(10'h003, 8'h00);
	endtask : t_cpu
	task automatic t_bufdma();
		for (int k = 0; k < 4; k++)
		begin
			role_select_i <= k[1];
			p0_dma_dir_in_i <= k[0];
			p0_buffer_drained_i <= 1'b0;
			wr(10'h004, 8'h87);
			pulse(4'h1);
			rchk(10'h004, {k[1] == k[0], 7'h00});
			p0_buffer_drained_i <= 1'b1;
			rchk(10'h004, 8'h80);
		end
		role_select_i <= 1'b0;
		wr(10'h004, 8'h80);
	endtask : t_bufdma
	task automatic t_area();
		p0_area_join_cpu_status_i <= 6'h08;
		p0_area_has_data_i <= 6'h04;
		p0_area_full_i <= 6'h04;
		p0_area_empty_i <= 6'h04;
		rchk(10'h004, 8'h00);
		p0_area_has_data_i <= 6'h08;
		p0_area_full_i <= 6'h08;
		rchk(10'h004, 8'h06);
		p0_area_full_i <= 6'h00;
		p0_area_empty_i <= 6'h08;
		rchk(10'h004, 8'h07);
		wr(10'h00c, 8'h04);
		wr(10'h008, 8'h10);
		wr(10'h004, 8'h07);
		rchk(10'h004, 8'h04);
		`CHK(irq_out_n_o, 1'b0)
		p0_area_has_data_i <= 6'h00;
		wr(10'h004, 8'h04);
		`CHK(irq_out_n_o, 1'b1)
	endtask : t_area
	task automatic t_summary();
		p0_device_flags_i <= 8'h80;
		power_transition_done_i <= 2'b01;
		wr(10'h003, 8'h83);
		wr(10'h009, 8'h80);
		wr(10'h008, 8'h81);
		rchk(10'h000, 8'h81);
		`CHK(irq_out_n_o, 1'b0)
		wr(10'h009, 8'h00);
		rchk(10'h000, 8'h01);
		wr(10'h008, 8'h00);
		`CHK(irq_out_n_o, 1'b1)
		role_select_i <= 1'b1;
		p0_host_flags_i <= 8'h40;
		wr(10'h00a, 8'h40);
		rchk(10'h000, 8'h41);
		wr(10'h00a, 8'h00);
		rchk(10'h000, 8'h01);
		role_select_i <= 1'b0;
		power_transition_done_i <= 2'b00;
	endtask : t_summary
	task automatic t_sleep();
		logic [9:0] sa [4] = '{10'h008, 10'h009, 10'h00a, 10'h00b};
		logic [7:0] se [4] = '{8'hc1, 8'ha0, 8'hc0, 8'h01};
		wr(10'h209, 8'hff);
		rchk(10'h209, 8'h00);
		sleep_i <= 2'b01;
		foreach (sa[k])
		begin
			wr(sa[k], 8'hff);
			rchk(sa[k], se[k]);
		end
		rchk(10'h010, REV);
		sleep_i <= 2'b00;
	endtask : t_sleep
	task automatic t_soft();
		wr(10'h011, 8'h00);
		`CHK(transceiver_reset_o, 1'b0)
		wr(10'h211, 8'h80);
		`CHK(transceiver_reset_o, 1'b1)
		wr(10'h011, 8'h81);
		`CHK(full_soft_reset_o, 1'b1)
		rchk(10'h008, 8'h00);
		rchk(10'h011, 8'h80);
	endtask : t_soft
	task automatic give_verdict();
		if (n_fail == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (5) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		t_reset();
		t_cpu();
		t_bufdma();
		t_area();
		t_summary();
		t_sleep();
		t_soft();
		give_verdict();
	end
	// Tests take well under a thousand cycles
	initial
	begin
		#400000;
		n_fail++;
		give_verdict();
	end
endmodule : test_usb_port_interrupt_and_reset_regs
